// *** common/ps_access_pkg.sv ***
package ps_access_pkg;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int PS_WORD_W   = 24;
    localparam int DS_WORD_W   = 16;
    localparam int PS_ADDR_W   = 24;
    localparam int PAGE_W      = 8;
    localparam int EA_W        = 16;
    localparam int PC_W        = 23;
    localparam int BYTE_W      = 8;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int PAGE_CFG_BIT = 7;
    localparam int UPPER_LSB    = 16;
    localparam int HIGH_LSB     = 8;

    // ==========================================================
    // Reset values and fills
    // ==========================================================
    localparam logic [PS_WORD_W-1:0] PS_WORD_RST = 24'h000000;
    localparam logic [DS_WORD_W-1:0] DS_WORD_RST = 16'h0000;
    localparam logic [PS_ADDR_W-1:0] PS_ADDR_RST = 24'h000000;
    localparam logic [BYTE_W-1:0]    BYTE_ZERO   = 8'h00;
    localparam logic [2:0]           LANE_NONE   = 3'h0;
    localparam logic [2:0]           LANE_LOW    = 3'h1;
    localparam logic [2:0]           LANE_HIGH   = 3'h2;
    localparam logic [2:0]           LANE_UPPER  = 3'h4;

    // ==========================================================
    // Access kinds
    // ==========================================================
    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_FETCH  = 5'h02,
        ST_TREAD  = 5'h04,
        ST_TWRITE = 5'h08,
        ST_WINDOW = 5'h10
    } access_state_t;

endpackage : ps_access_pkg

// *** design/ps_lane_steer.sv ***
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Byte/word lane steering between program and data words
// ==========================================================
module ps_lane_steer
(
    // Selection
    input  wire logic        i_upper,
    input  wire logic        i_byte,
    input  wire logic        i_odd,
    // Program word in, steered data out
    input  wire logic [23:0] i_ps_word,
    output logic      [15:0] o_ds_read,
    // Data in, lane enables out
    input  wire logic [15:0] i_ds_write,
    output logic      [23:0] o_ps_write,
    output logic      [2:0]  o_lanes
);

    always_comb
    begin
        o_ds_read  = ps_access_pkg::DS_WORD_RST;
        o_ps_write = ps_access_pkg::PS_WORD_RST;
        o_lanes    = ps_access_pkg::LANE_NONE;
        if (i_upper)
        begin
            // Upper byte sits alone; odd address reads phantom zero
            o_ds_read = i_odd ? ps_access_pkg::DS_WORD_RST
                : {ps_access_pkg::BYTE_ZERO,
                   i_ps_word[ps_access_pkg::UPPER_LSB +: 8]};
            o_ps_write[ps_access_pkg::UPPER_LSB +: 8] = i_ds_write[7:0];
            o_lanes = i_odd ? ps_access_pkg::LANE_NONE
                : ps_access_pkg::LANE_UPPER;
        end
        else if (i_byte)
        begin
            o_ds_read = {ps_access_pkg::BYTE_ZERO,
                i_odd ? i_ps_word[ps_access_pkg::HIGH_LSB +: 8]
                      : i_ps_word[7:0]};
            o_ps_write[15:0] = {i_ds_write[7:0], i_ds_write[7:0]};
            o_lanes = i_odd ? ps_access_pkg::LANE_HIGH
                : ps_access_pkg::LANE_LOW;
        end
        else
        begin
            o_ds_read        = i_ps_word[15:0];
            o_ps_write[15:0] = i_ds_write;
            o_lanes          = ps_access_pkg::LANE_LOW
                             | ps_access_pkg::LANE_HIGH;
        end
    end

endmodule : ps_lane_steer

`default_nettype wire

// *** design/program_space_access.sv ***
`timescale 1ns/100ps
`default_nettype none

module program_space_access
(
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_reset,
    // Requests from the core (one-cycle strobes)
    input  wire logic        i_fetch,
    input  wire logic [22:0] i_pc,
    input  wire logic        i_table_read_op,
    input  wire logic        i_table_write_op,
    input  wire logic        i_table_upper,
    input  wire logic        i_table_byte,
    input  wire logic [7:0]  i_table_page_sel,
    input  wire logic [15:0] i_ea,
    input  wire logic [15:0] i_ds_wdata,
    input  wire logic        i_window_read,
    input  wire logic        i_window_write,
    input  wire logic [22:0] i_window_addr,
    // Program store port
    output logic      [23:0] o_ps_addr,
    output logic             o_ps_rd,
    output logic             o_ps_wr,
    output logic      [2:0]  o_ps_lanes,
    output logic      [23:0] o_ps_wdata,
    output logic             o_ps_cfg,
    input  wire logic [23:0] i_ps_rdata,
    // Answers to the core
    output logic      [23:0] o_instr,
    output logic             o_instr_valid,
    output logic      [15:0] o_ds_rdata,
    output logic             o_ds_valid,
    output logic             o_window_dropped
);

    // ==========================================================
    // State
    // ==========================================================
    ps_access_pkg::access_state_t state;
    ps_access_pkg::access_state_t next_state;
    logic        upper_q;
    logic        byte_q;
    logic        odd_q;
    logic [15:0] steer_rdata;
    logic [2:0]  steer_lanes;

    // Word address: bit 23 and bit 0 forced low
    function automatic logic [23:0] fetch_addr(input logic [22:0] pc);
        fetch_addr = {1'b0, pc[22:1], 1'b0};
    endfunction : fetch_addr

    // Byte address: page over effective address
    function automatic logic [23:0] table_addr(input logic [7:0]  page,
                                               input logic [15:0] ea);
        table_addr = {page, ea};
    endfunction : table_addr

    // ==========================================================
    // Request arbitration, fetch first
    // ==========================================================
    // Lower-priority requests in the same cycle are dropped
    always_comb
    begin
        next_state = ps_access_pkg::ST_IDLE;
        if (i_fetch)
            next_state = ps_access_pkg::ST_FETCH;
        else if (i_table_read_op)
            next_state = ps_access_pkg::ST_TREAD;
        else if (i_table_write_op)
            next_state = ps_access_pkg::ST_TWRITE;
        else if (i_window_read)
            next_state = ps_access_pkg::ST_WINDOW;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
            state <= ps_access_pkg::ST_IDLE;
        else
            state <= next_state;
    end

    // ==========================================================
    // Address construction
    // ==========================================================
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            o_ps_addr <= ps_access_pkg::PS_ADDR_RST;
            o_ps_cfg  <= 1'b0;
            upper_q   <= 1'b0;
            byte_q    <= 1'b0;
            odd_q     <= 1'b0;
        end
        else
        begin
            case (next_state)
                ps_access_pkg::ST_FETCH:
                begin
                    o_ps_addr <= fetch_addr(i_pc);
                    o_ps_cfg  <= 1'b0;
                end
                ps_access_pkg::ST_TREAD,
                ps_access_pkg::ST_TWRITE:
                begin
                    o_ps_addr <= table_addr(i_table_page_sel, i_ea);
                    o_ps_cfg  <=
                        i_table_page_sel[ps_access_pkg::PAGE_CFG_BIT];
                    upper_q   <= i_table_upper;
                    byte_q    <= i_table_byte;
                    odd_q     <= i_ea[0];
                end
                ps_access_pkg::ST_WINDOW:
                begin
                    // Window reaches the low word of user space only
                    o_ps_addr <= fetch_addr(i_window_addr);
                    o_ps_cfg  <= 1'b0;
                    upper_q   <= 1'b0;
                    byte_q    <= 1'b0;
                    odd_q     <= 1'b0;
                end
                default:
                begin
                    o_ps_addr <= o_ps_addr;
                end
            endcase
        end
    end

    // ==========================================================
    // Width translation
    // ==========================================================
    ps_lane_steer ps_lane_steer_i
    (
        .i_upper    (upper_q),
        .i_byte     (byte_q),
        .i_odd      (odd_q),
        .i_ps_word  (i_ps_rdata),
        .o_ds_read  (steer_rdata),
        .i_ds_write (i_ds_wdata),
        .o_ps_write (),
        .o_lanes    (steer_lanes)
    );

    // Write data latched with the request, in step with the address
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            o_ps_wdata <= ps_access_pkg::PS_WORD_RST;
        end
        else if (next_state == ps_access_pkg::ST_TWRITE)
        begin
            o_ps_wdata <= ps_access_pkg::PS_WORD_RST;
            if (i_table_upper)
                o_ps_wdata[ps_access_pkg::UPPER_LSB +: 8] <=
                    i_ds_wdata[7:0];
            else if (i_table_byte)
                o_ps_wdata[15:0] <= {i_ds_wdata[7:0], i_ds_wdata[7:0]};
            else
                o_ps_wdata[15:0] <= i_ds_wdata;
        end
    end

    // ==========================================================
    // Program store strobes
    // ==========================================================
    always_comb
    begin
        o_ps_rd    = (state == ps_access_pkg::ST_FETCH)
                   | (state == ps_access_pkg::ST_TREAD)
                   | (state == ps_access_pkg::ST_WINDOW);
        // Only table writes raise the write strobe; lanes shown while writing
        o_ps_wr    = (state == ps_access_pkg::ST_TWRITE);
        o_ps_lanes = o_ps_wr ? steer_lanes : ps_access_pkg::LANE_NONE;
    end

    // ==========================================================
    // Answers
    // ==========================================================
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            o_instr          <= ps_access_pkg::PS_WORD_RST;
            o_instr_valid    <= 1'b0;
            o_ds_rdata       <= ps_access_pkg::DS_WORD_RST;
            o_ds_valid       <= 1'b0;
            o_window_dropped <= 1'b0;
        end
        else
        begin
            o_instr_valid    <= (state == ps_access_pkg::ST_FETCH);
            o_ds_valid       <= (state == ps_access_pkg::ST_TREAD)
                              | (state == ps_access_pkg::ST_WINDOW);
            // Window writes never reach the store, only flagged
            o_window_dropped <= i_window_write;
            if (state == ps_access_pkg::ST_FETCH)
                o_instr <= i_ps_rdata;
            if (state == ps_access_pkg::ST_TREAD)
                o_ds_rdata <= steer_rdata;
            else if (state == ps_access_pkg::ST_WINDOW)
                o_ds_rdata <= i_ps_rdata[15:0];
        end
    end

endmodule : program_space_access

`default_nettype wire

// *** test/program_space_access_props.sv ***
`timescale 1ns/100ps
`default_nettype none

module program_space_access_props
(
    // Core side
    input wire logic        i_mclk,
    input wire logic        i_reset,
    input wire logic        i_fetch,
    input wire logic [22:0] i_pc,
    input wire logic        i_table_read_op,
    input wire logic        i_table_write_op,
    input wire logic        i_table_upper,
    input wire logic        i_table_byte,
    input wire logic [7:0]  i_table_page_sel,
    input wire logic [15:0] i_ea,
    input wire logic        i_window_read,
    input wire logic        i_window_write,
    // Store side and answers
    input wire logic [23:0] o_ps_addr,
    input wire logic        o_ps_rd,
    input wire logic        o_ps_wr,
    input wire logic [2:0]  o_ps_lanes,
    input wire logic        o_ps_cfg,
    input wire logic [23:0] i_ps_rdata,
    input wire logic [23:0] o_instr,
    input wire logic        o_instr_valid,
    input wire logic [15:0] o_ds_rdata,
    input wire logic        o_ds_valid,
    input wire logic        o_window_dropped
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    wire rd_only = i_table_read_op & ~i_fetch;
    wire wr_only = i_table_write_op & ~i_fetch & ~i_table_read_op;
    wire win_only = i_window_read & ~rd_only & ~i_fetch & ~i_table_write_op;

    fetch_addr_a: assert property (
        i_fetch |=> o_ps_rd && o_ps_addr == {1'b0, $past(i_pc[22:1]), 1'b0})
        else $error("fetch address wrong");
    table_addr_a: assert property (
        rd_only |=> o_ps_addr == {$past(i_table_page_sel), $past(i_ea)}
        && o_ps_cfg == $past(i_table_page_sel[7])) else $error("table addr");
    instr_full_a: assert property (
        i_fetch |=> ##1 o_instr_valid && o_instr == $past(i_ps_rdata))
        else $error("instruction word wrong");
    window_low_a: assert property (
        win_only |=> ##1 o_ds_valid && o_ds_rdata == $past(i_ps_rdata[15:0]))
        else $error("window read wrong");
    window_drop_a: assert property (
        i_window_write && !i_table_write_op |=> o_window_dropped && !o_ps_wr)
        else $error("window write not dropped");
    upper_lane_a: assert property (
        wr_only && i_table_upper && !i_ea[0]
        |=> o_ps_wr && o_ps_lanes == 3'h4)
        else $error("upper lane wrong");
    word_read_a: assert property (
        rd_only && !i_table_byte && !i_table_upper
        |=> ##1 o_ds_rdata == $past(i_ps_rdata[15:0]))
        else $error("word read");
    byte_lane_a: assert property (
        wr_only && i_table_byte && !i_table_upper
        |=> o_ps_lanes == ($past(i_ea[0]) ? 3'h2 : 3'h1)) else $error("lane");

    fetch_c: cover property (i_fetch);
    upper_c: cover property (wr_only && i_table_upper);
    drop_c: cover property (i_window_write);
    window_c: cover property (win_only);
endmodule : program_space_access_props

bind program_space_access program_space_access_props
    program_space_access_props_i (.i_mclk, .i_reset, .i_fetch, .i_pc,
    .i_table_read_op, .i_table_write_op, .i_table_upper, .i_table_byte,
    .i_table_page_sel, .i_ea, .i_window_read, .i_window_write, .o_ps_addr,
    .o_ps_rd, .o_ps_wr, .o_ps_lanes, .o_ps_cfg, .i_ps_rdata, .o_instr,
    .o_instr_valid, .o_ds_rdata, .o_ds_valid, .o_window_dropped);

`default_nettype wire

// *** test/ps_store_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module ps_store_model
(
    // Store port
    input  wire logic        i_mclk,
    input  wire logic [23:0] i_addr,
    input  wire logic        i_rd,
    input  wire logic        i_wr,
    input  wire logic [2:0]  i_lanes,
    input  wire logic [23:0] i_wdata,
    output logic      [23:0] o_rdata
);
    logic [23:0] mem [16];
    wire  [3:0]  idx = i_addr[4:1];
    initial
    begin
        for (int i = 0; i < 16; i++)
            mem[i] = {4'hA, 4'(i), 4'h5, 4'(i), 4'h3, 4'(i)};
    end
    // Released bus shows the inverse
    assign o_rdata = i_rd ? mem[idx] : ~mem[idx];
    always @(posedge i_mclk)
    begin
        for (int l = 0; l < 3; l++)
            if (i_wr && i_lanes[l])
                mem[idx][8*l +: 8] <= i_wdata[8*l +: 8];
    end
endmodule : ps_store_model

`default_nettype wire

// *** test/program_space_access_bench.sv ***
`timescale 1ns/100ps
`default_nettype none

module program_space_access_bench;
    logic        i_mclk, i_reset, i_fetch, i_table_read_op;
    logic        i_table_write_op, i_table_upper, i_table_byte;
    logic        i_window_read, i_window_write, o_window_dropped;
    logic        o_ps_rd, o_ps_wr, o_ps_cfg, o_instr_valid, o_ds_valid;
    logic [22:0] i_pc, i_window_addr;
    logic [7:0]  i_table_page_sel;
    logic [15:0] i_ea, i_ds_wdata, o_ds_rdata;
    logic [23:0] o_ps_addr, o_ps_wdata, i_ps_rdata, o_instr, w;
    logic [2:0]  o_ps_lanes;
    int          err_count, compares, cycles;

    program_space_access program_space_access_i (.i_mclk, .i_reset,
        .i_fetch, .i_pc, .i_table_read_op, .i_table_write_op,
        .i_table_upper, .i_table_byte, .i_table_page_sel, .i_ea,
        .i_ds_wdata, .i_window_read, .i_window_write, .i_window_addr,
        .o_ps_addr, .o_ps_rd, .o_ps_wr, .o_ps_lanes, .o_ps_wdata, .o_ps_cfg,
        .i_ps_rdata, .o_instr, .o_instr_valid, .o_ds_rdata, .o_ds_valid,
        .o_window_dropped);
    ps_store_model ps_store_model_i (.i_mclk, .i_addr(o_ps_addr),
        .i_rd(o_ps_rd), .i_wr(o_ps_wr), .i_lanes(o_ps_lanes),
        .i_wdata(o_ps_wdata), .o_rdata(i_ps_rdata));

    always #5 i_mclk = ~i_mclk;

    function automatic logic [23:0] pat(input logic [3:0] i);
        return {4'hA, i, 4'h5, i, 4'h3, i};
    endfunction : pat

    task chk(input logic [23:0] got, input logic [23:0] exp, input string m);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk

    task settle;
        @(negedge i_mclk);
        i_fetch = 1'b0;
        i_table_read_op = 1'b0;
        i_table_write_op = 1'b0;
        i_window_read = 1'b0;
        i_window_write = 1'b0;
    endtask : settle

    task tbl(input logic rd, up, by, input logic [7:0] pg,
             input logic [15:0] ea);
        @(negedge i_mclk);
        i_table_read_op = rd;
        i_table_write_op = ~rd;
        i_table_upper = up;
        i_table_byte = by;
        i_table_page_sel = pg;
        i_ea = ea;
        settle;
        chk(o_ps_addr, {pg, ea}, "table addr");
        chk({23'h0, o_ps_cfg}, {23'h0, pg[7]}, "space select");
        chk({22'h0, o_ps_wr, o_ps_rd}, {22'h0, ~rd, rd}, "strobe");
        if (rd)
            @(negedge i_mclk);
    endtask : tbl

    task t_fetch;
        @(negedge i_mclk);
        i_fetch = 1'b1;
        i_table_read_op = 1'b1;
        i_pc = 23'h2AAAAB;
        settle;
        chk(o_ps_addr, 24'h2AAAAA, "fetch addr");
        @(negedge i_mclk);
        chk(o_instr, pat(4'h5), "fetch word");
        chk({22'h0, o_instr_valid, o_ds_valid}, 24'h2, "priority");
    endtask : t_fetch

    task t_reads;
        w = pat(4'h3);
        tbl(1'b1, 1'b0, 1'b0, 8'h81, 16'h0006);
        chk({8'h0, o_ds_rdata}, {8'h0, w[15:0]}, "word read");
        tbl(1'b1, 1'b0, 1'b1, 8'h02, 16'h0006);
        chk({8'h0, o_ds_rdata}, {16'h0, w[7:0]}, "even byte");
        tbl(1'b1, 1'b0, 1'b1, 8'h81, 16'h0007);
        chk({8'h0, o_ds_rdata}, {16'h0, w[15:8]}, "odd byte");
        tbl(1'b1, 1'b1, 1'b1, 8'h81, 16'h0006);
        chk({8'h0, o_ds_rdata}, {16'h0, w[23:16]}, "upper byte");
        tbl(1'b1, 1'b1, 1'b1, 8'h81, 16'h0007);
        chk({8'h0, o_ds_rdata}, 24'h0, "odd upper");
    endtask : t_reads

    task t_write;
        i_ds_wdata = 16'h1234;
        tbl(1'b0, 1'b0, 1'b1, 8'h00, 16'h001F);
        w = {4'h0, o_ps_wr, o_ps_lanes, o_ps_wdata[15:0]};
        chk(w, 24'h0A3434, "byte wr");
        i_ds_wdata = 16'h0056;
        tbl(1'b0, 1'b1, 1'b1, 8'h00, 16'h001E);
        chk({20'h0, o_ps_wr, o_ps_lanes}, 24'h0C, "upper wr");
        chk(o_ps_wdata, 24'h560000, "upper data");
        i_ds_wdata = 16'hBEEF;
        tbl(1'b0, 1'b0, 1'b0, 8'h00, 16'h001C);
        w = {4'h0, o_ps_wr, o_ps_lanes, o_ps_wdata[15:0]};
        chk(w, 24'h0BBEEF, "word wr");
        tbl(1'b1, 1'b0, 1'b0, 8'h00, 16'h001C);
        chk({8'h0, o_ds_rdata}, 24'h00BEEF, "word wr back");
        tbl(1'b1, 1'b1, 1'b1, 8'h00, 16'h001C);
        chk({8'h0, o_ds_rdata}, 24'h0000AE, "upper kept");
        tbl(1'b1, 1'b0, 1'b0, 8'h00, 16'h001E);
        chk({8'h0, o_ds_rdata}, 24'h343F, "word back");
        tbl(1'b1, 1'b1, 1'b1, 8'h00, 16'h001E);
        chk({8'h0, o_ds_rdata}, 24'h56, "upper back");
    endtask : t_write

    task t_window;
        w = pat(4'hD);
        @(negedge i_mclk);
        i_window_write = 1'b1;
        i_window_addr = 23'h00001A;
        i_ds_wdata = 16'hFFFF;
        settle;
        chk({22'h0, o_ps_wr, o_window_dropped}, 24'h1, "window write");
        i_window_read = 1'b1;
        settle;
        @(negedge i_mclk);
        chk({7'h0, o_ds_valid, o_ds_rdata}, {8'h1, w[15:0]}, "window");
    endtask : t_window

    task wrap_up;
        if (err_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up

    always @(posedge i_mclk)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            err_count++;
            $display("BAD %0t timeout", $time);
            wrap_up;
        end
    end

    initial
    begin
        {i_mclk, i_fetch, i_table_read_op, i_table_write_op} = 4'h0;
        {i_table_upper, i_table_byte, i_window_read, i_window_write} = 4'h0;
        {i_pc, i_window_addr, i_table_page_sel, i_ea, i_ds_wdata} = '0;
        i_reset = 1'b1;
        repeat (20) @(negedge i_mclk);
        i_reset = 1'b0;
        t_fetch;
        t_reads;
        t_write;
        t_window;
        wrap_up;
    end
endmodule : program_space_access_bench

`default_nettype wire
